/* rtl/link_err_params.svh */
`ifndef LINK_ERR_PARAMS_SVH
`define LINK_ERR_PARAMS_SVH
`define ERR_STATUS_ADDR    16'h0219
`define ERR_STATUS_RESET   8'h00
`define BIT_RWDATA         6
`define BIT_TIMEOUT        5
`define BIT_CHECKSUM       4
`define BIT_LEN_PARITY     3
`define BIT_RW_PARITY      2
`define BIT_HEADER         1
`define BIT_FRAMING        0
`define TIMEOUT_FIELDS     3
`define RECOVER_FIELDS     4
`define FIELD_BITS         10
`define BIT_CYCLES_DEF     16'd1000
`endif

/* rtl/link_err_pkg.sv */
package link_err_pkg;
  typedef enum logic [2:0] {
    MODE_STANDBY = 3'b001,
    MODE_COMM    = 3'b010,
    MODE_ERROR   = 3'b100
  } link_mode_t;
  typedef logic [6:0] err_flags_t;
endpackage : link_err_pkg

/* rtl/field_timer_if.sv */
`timescale 1ns/1ns
interface field_timer_if;
  logic       restart;
  logic [3:0] fields;
  modport owner (output restart, input fields);
  modport timer (input restart, output fields);
endinterface : field_timer_if

/* rtl/field_timer.sv */
`timescale 1ns/1ns
`include "link_err_params.svh"
module field_timer #(
  parameter int BIT_CYCLES = `BIT_CYCLES_DEF
) (
  input  wire logic   clk,
  input  wire logic   rst_b,
  field_timer_if.timer tif
);
  localparam int FIELD_CYCLES = BIT_CYCLES * `FIELD_BITS;
  // Cycle counter is 16 bits wide, so one field must fit in it
  if (BIT_CYCLES < 1 || FIELD_CYCLES > 65535) begin : g_bad_bit_cycles
    $error("BIT_CYCLES out of range");
  end
  logic [15:0] cyc_q;
  logic [3:0]  fields_q;

  // Counts whole field durations since last restart, saturating at 15
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_q    <= 16'h0000;
      fields_q <= 4'h0;
    end else if (tif.restart) begin
      cyc_q    <= 16'h0000;
      fields_q <= 4'h0;
    end else if (cyc_q == 16'(FIELD_CYCLES - 1)) begin
      cyc_q <= 16'h0000;
      if (fields_q != 4'hf) fields_q <= fields_q + 4'h1;
    end else begin
      cyc_q <= cyc_q + 16'h0001;
    end
  end
  assign tif.fields = fields_q;
endmodule : field_timer

/* rtl/link_err_handler.sv */
// What this block does
// - A write checksum mismatch sets flag bit 4, enters error mode and ends the communication.
// - After a checksum error the failing block is dropped while earlier good blocks stay committed.
// - Every error except the field data error and the time-out sets its flag and forces error mode.
// - Error mode ends, into standby, once the line has stayed high more than four field times.
// - Recovery from error mode ignores the error status contents.
// - Flags stay set across mode changes until the status register is read.
// - A single one-byte read of the status register clears all flags not set in that same cycle after returning them.
// - A multi-byte read covering the status register returns flags without clearing.
// - Nonzero read/write field bits 5..1 set flag 6, keep communication on and nullify the access.
// - An inter-field gap over three field times sets flag 5, ends communication and enters standby.
// - Flags 3,2,1,0 report length parity, read/write parity, header and stop-bit framing errors.
// - A time-out during a long write keeps earlier good blocks committed and goes to standby.
`timescale 1ns/1ns
`include "link_err_params.svh"
module link_err_handler #(
  parameter int BIT_CYCLES = `BIT_CYCLES_DEF
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_B,
  input  wire logic       LINE_IN,
  input  wire logic       FIELD_DONE,
  input  wire logic       FRAME_START,
  input  wire logic       WRITE_MODE,
  input  wire logic       BLOCK_CHECKED,
  input  wire logic       CHECKSUM_OK,
  input  wire logic       RW_DATA_ERR,
  input  wire logic       LEN_PARITY_ERR,
  input  wire logic       RW_PARITY_ERR,
  input  wire logic       HEADER_ERR,
  input  wire logic       FRAMING_ERR,
  input  wire logic       READ_DONE,
  input  wire logic [15:0] READ_ADDR,
  input  wire logic [7:0] READ_LEN,
  output logic [7:0]      STATUS_DATA,
  output logic [2:0]      MODE,
  output logic            COMM_ABORT,
  output logic            COMMIT_BLOCK,
  output logic            NULLIFY
);
  // A zero bit time would stretch every field count to 65536 cycles
  if (BIT_CYCLES < 1) begin : g_bad_cfg
    $error("BIT_CYCLES must be at least one");
  end

  // ---------------------------------------------------------------
  // Timer
  // ---------------------------------------------------------------
  field_timer_if tif ();
  field_timer #(.BIT_CYCLES(BIT_CYCLES)) u_timer (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .tif   (tif)
  );

  link_err_pkg::link_mode_t  mode_q;
  link_err_pkg::err_flags_t  flags_q;
  link_err_pkg::err_flags_t  set_d;
  logic                      fatal_err;
  logic                      timeout;
  logic                      recovered;
  logic                      clr_read;

  assign fatal_err = (WRITE_MODE && BLOCK_CHECKED && !CHECKSUM_OK) || LEN_PARITY_ERR
                   || RW_PARITY_ERR || HEADER_ERR || FRAMING_ERR;
  assign timeout   = (mode_q == link_err_pkg::MODE_COMM)
                   && (tif.fields >= 4'(`TIMEOUT_FIELDS)) && !FIELD_DONE;
  // Only flags-free condition matters here; no look at flags_q
  assign recovered = (mode_q == link_err_pkg::MODE_ERROR)
                   && (tif.fields >= 4'(`RECOVER_FIELDS)) && LINE_IN;
  assign clr_read  = READ_DONE && (READ_ADDR == `ERR_STATUS_ADDR) && (READ_LEN == 8'h01);

  // Restart on field edges or frame start in comm, on low line in error, and always in standby
  always_comb begin
    case (mode_q)
      link_err_pkg::MODE_COMM:  tif.restart = FIELD_DONE || FRAME_START;
      link_err_pkg::MODE_ERROR: tif.restart = !LINE_IN;
      default:                  tif.restart = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // Error flags
  // ---------------------------------------------------------------
  always_comb begin
    set_d = '0;
    if (mode_q == link_err_pkg::MODE_COMM) begin
      set_d[`BIT_RWDATA]     = RW_DATA_ERR;
      set_d[`BIT_TIMEOUT]    = timeout;
      set_d[`BIT_CHECKSUM]   = WRITE_MODE && BLOCK_CHECKED && !CHECKSUM_OK;
      set_d[`BIT_LEN_PARITY] = LEN_PARITY_ERR;
      set_d[`BIT_RW_PARITY]  = RW_PARITY_ERR;
      set_d[`BIT_HEADER]     = HEADER_ERR;
      set_d[`BIT_FRAMING]    = FRAMING_ERR;
    end
  end

  // Set wins over a same-cycle read clear
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) flags_q <= 7'h00;
    else if (clr_read) flags_q <= set_d;
    else flags_q <= flags_q | set_d;
  end

  // ---------------------------------------------------------------
  // Mode
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) mode_q <= link_err_pkg::MODE_STANDBY;
    else begin
      case (mode_q)
        link_err_pkg::MODE_STANDBY: if (FRAME_START) mode_q <= link_err_pkg::MODE_COMM;
        link_err_pkg::MODE_COMM: begin
          if (fatal_err) mode_q <= link_err_pkg::MODE_ERROR;
          else if (timeout) mode_q <= link_err_pkg::MODE_STANDBY;
        end
        link_err_pkg::MODE_ERROR: if (recovered) mode_q <= link_err_pkg::MODE_STANDBY;
        default: mode_q <= link_err_pkg::MODE_STANDBY;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      STATUS_DATA  <= `ERR_STATUS_RESET;
      MODE         <= link_err_pkg::MODE_STANDBY;
      COMM_ABORT   <= 1'b0;
      COMMIT_BLOCK <= 1'b0;
      NULLIFY      <= 1'b0;
    end else begin
      STATUS_DATA  <= {1'b0, flags_q | set_d};
      MODE         <= mode_q;
      COMM_ABORT   <= (mode_q == link_err_pkg::MODE_COMM) && (fatal_err || timeout);
      // Good blocks commit one by one; a bad block never does
      COMMIT_BLOCK <= (mode_q == link_err_pkg::MODE_COMM) && WRITE_MODE && BLOCK_CHECKED
                      && CHECKSUM_OK && !fatal_err;
      NULLIFY      <= (mode_q == link_err_pkg::MODE_COMM)
                      && (RW_DATA_ERR || fatal_err);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_cksum_err;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (mode_q == link_err_pkg::MODE_COMM && WRITE_MODE && BLOCK_CHECKED && !CHECKSUM_OK)
      |=> (mode_q == link_err_pkg::MODE_ERROR) && flags_q[`BIT_CHECKSUM] && COMM_ABORT && NULLIFY;
  endproperty
  a_cksum_err: assert property (p_cksum_err) else $error("checksum error not handled");

  property p_read_cksum;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (mode_q == link_err_pkg::MODE_COMM && !WRITE_MODE && BLOCK_CHECKED && !CHECKSUM_OK
       && !fatal_err && !timeout && !clr_read)
      |=> mode_q == link_err_pkg::MODE_COMM && flags_q[`BIT_CHECKSUM] == $past(flags_q[`BIT_CHECKSUM]);
  endproperty
  a_read_cksum: assert property (p_read_cksum) else $error("read block raised checksum error");

  property p_commit_good;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (mode_q == link_err_pkg::MODE_COMM && WRITE_MODE && BLOCK_CHECKED && CHECKSUM_OK && !fatal_err)
      |=> COMMIT_BLOCK;
  endproperty
  a_commit_good: assert property (p_commit_good) else $error("good block not committed");

  property p_no_commit_bad;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (BLOCK_CHECKED && !CHECKSUM_OK) |=> !COMMIT_BLOCK;
  endproperty
  a_no_commit_bad: assert property (p_no_commit_bad) else $error("bad block committed");

  property p_fatal_mode;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (mode_q == link_err_pkg::MODE_COMM && (LEN_PARITY_ERR || RW_PARITY_ERR || HEADER_ERR || FRAMING_ERR))
      |=> mode_q == link_err_pkg::MODE_ERROR && COMM_ABORT;
  endproperty
  a_fatal_mode: assert property (p_fatal_mode) else $error("error mode not entered");

  property p_recover;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (mode_q == link_err_pkg::MODE_ERROR && LINE_IN && tif.fields >= 4'(`RECOVER_FIELDS))
      |=> mode_q == link_err_pkg::MODE_STANDBY;
  endproperty
  a_recover: assert property (p_recover) else $error("no recovery after idle");

  property p_sticky;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (flags_q != 7'h00 && !clr_read) |=> (flags_q & $past(flags_q)) == $past(flags_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without read");

  property p_multi_keep;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (READ_DONE && READ_LEN != 8'h01) |=> (flags_q & $past(flags_q)) == $past(flags_q);
  endproperty
  a_multi_keep: assert property (p_multi_keep) else $error("multi-byte read cleared flags");

  property p_clear;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (clr_read && set_d == 7'h00) |=> flags_q == 7'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("single read did not clear");

  property p_rwdata;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (mode_q == link_err_pkg::MODE_COMM && RW_DATA_ERR && !fatal_err && !timeout)
      |=> flags_q[`BIT_RWDATA] && mode_q == link_err_pkg::MODE_COMM;
  endproperty
  a_rwdata: assert property (p_rwdata) else $error("rw data error mishandled");

  property p_nullify_rw;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (mode_q == link_err_pkg::MODE_COMM && RW_DATA_ERR) |=> NULLIFY;
  endproperty
  a_nullify_rw: assert property (p_nullify_rw) else $error("rw data access not nullified");

  property p_timeout;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (timeout && !fatal_err) |=> flags_q[`BIT_TIMEOUT] && mode_q == link_err_pkg::MODE_STANDBY && COMM_ABORT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out mishandled");
endmodule : link_err_handler

/* bench/line_master.sv */
`timescale 1ns/1ns
module line_master (
  input  wire logic clk,
  output logic      line
);
  initial line = 1'b1;
  // Master pulls the pin low while a frame runs
  task automatic frame_low();
    @(posedge clk);
    #1 line = 1'b0;
  endtask : frame_low
  // Releases the pin high and waits cyc cycles; the pin stays high after return
  task automatic idle_high(input int cyc);
    @(posedge clk);
    #1 line = 1'b1;
    repeat (cyc) @(posedge clk);
    #1;
  endtask : idle_high
endmodule : line_master

/* bench/test_serial_link_error_handler.sv */
`timescale 1ns/1ns
module test_serial_link_error_handler;
  localparam int FLD = 20;
  logic clk_sys, rst_b, line_in, fld_done, frm_start, blk_chk, cs_ok, rd_done, wr_mode;
  logic [6:0]  err;
  logic [15:0] rd_addr;
  logic [7:0]  rd_len, status;
  logic [2:0]  mode;
  logic        abort, commit, nullify;
  int n_errors = 0, num_checks = 0, n_ab = 0, n_cm = 0, n_nl = 0, b0, b1, b2;
  line_master m (.clk(clk_sys), .line(line_in));
  link_err_handler #(.BIT_CYCLES(2)) DUT (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .LINE_IN(line_in), .FIELD_DONE(fld_done),
    .FRAME_START(frm_start), .WRITE_MODE(wr_mode), .BLOCK_CHECKED(blk_chk), .CHECKSUM_OK(cs_ok),
    .RW_DATA_ERR(err[6]), .LEN_PARITY_ERR(err[3]), .RW_PARITY_ERR(err[2]), .HEADER_ERR(err[1]),
    .FRAMING_ERR(err[0]), .READ_DONE(rd_done), .READ_ADDR(rd_addr), .READ_LEN(rd_len),
    .STATUS_DATA(status), .MODE(mode), .COMM_ABORT(abort), .COMMIT_BLOCK(commit), .NULLIFY(nullify));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Pulses are one cycle wide, so count them as they pass
  always @(posedge clk_sys) begin
    n_ab += abort;
    n_cm += commit;
    n_nl += nullify;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic start();
    m.frame_low();
    frm_start = 1'b1;
    cyc(1);
    frm_start = 1'b0;
    cyc(3);
  endtask : start
  task automatic blk(input logic ok);
    cs_ok = ok;
    blk_chk = 1'b1;
    cyc(1);
    blk_chk = 1'b0;
    cyc(3);
  endtask : blk
  task automatic epulse(input int i);
    err[i] = 1'b1;
    cyc(1);
    err = '0;
    cyc(3);
  endtask : epulse
  task automatic rd(input logic [15:0] a, input logic [7:0] n);
    rd_addr = a;
    rd_len = n;
    rd_done = 1'b1;
    cyc(1);
    rd_done = 1'b0;
    cyc(3);
  endtask : rd
  task automatic wait_mode(input logic [2:0] exp, input int lim);
    int k;
    for (k = 0; k < lim && mode !== exp; k++) cyc(1);
    check(mode, exp);
    if (mode !== exp) results();
  endtask : wait_mode
  task automatic results();
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    {rst_b, fld_done, frm_start, blk_chk, cs_ok, rd_done, err, rd_addr, rd_len} = '0;
    wr_mode = 1'b1;
    cyc(8);
    rst_b = 1'b1;
    cyc(1);
    check(mode, 8'h01);
    check(status, 8'h00);
    start();
    check(mode, 8'h02);
    blk(1'b1);
    blk(1'b0);
    check(mode, 8'h04);
    check(status, 8'h10);
    check(8'(n_ab), 8'h01);
    check(8'(n_nl), 8'h01);
    check(8'(n_cm), 8'h01);
    m.idle_high(4 * FLD - 10);
    check(mode, 8'h04);
    wait_mode(3'b001, 40);
    check(status, 8'h10);
    rd(16'h0219, 8'h02);
    check(status, 8'h10);
    rd(16'h0218, 8'h01);
    check(status, 8'h10);
    rd(16'h0219, 8'h01);
    check(status, 8'h00);
    for (int i = 0; i < 4; i++) begin
      start();
      epulse(i);
      check(mode, 8'h04);
      check(status, 8'(1 << i));
      m.idle_high(4 * FLD + 10);
      wait_mode(3'b001, 20);
      rd(16'h0219, 8'h01);
      check(status, 8'h00);
    end
    // Framer errors outside a frame must be ignored
    epulse(1);
    check(mode, 8'h01);
    check(status, 8'h00);
    start();
    b0 = n_nl;
    epulse(6);
    check(mode, 8'h02);
    check(status, 8'h40);
    check(8'(n_nl - b0), 8'h01);
    {b0, b1, b2} = {n_ab, n_cm, n_nl};
    blk(1'b1);
    // A bad block in read mode is no checksum error
    wr_mode = 1'b0;
    blk(1'b0);
    check(mode, 8'h02);
    check(status, 8'h40);
    check(8'(n_nl - b2), 8'h00);
    wr_mode = 1'b1;
    fld_done = 1'b1;
    cyc(1);
    fld_done = 1'b0;
    cyc(3 * FLD - 8);
    check(mode, 8'h02);
    wait_mode(3'b001, 30);
    check(status, 8'h60);
    check(8'(n_ab - b0), 8'h01);
    check(8'(n_cm - b1), 8'h01);
    rd(16'h0219, 8'h01);
    check(status, 8'h00);
    results();
  end
endmodule : test_serial_link_error_handler
